//--- hdl/rtc_pkg.sv
// Constants, register map and types for the serial real-time clock core.
// Assumes a 50 MHz system clock and a free-running 32.768 kHz oscillator pin.
package rtc_pkg;
	localparam int unsigned REG_COUNT = 16;
	localparam int unsigned ADDR_W    = 4;

	localparam logic [3:0] REG_CTRL1 = 4'h0;
	localparam logic [3:0] REG_CTRL2 = 4'h1;
	localparam logic [3:0] REG_SEC   = 4'h2;
	localparam logic [3:0] REG_YEAR  = 4'h8;
	localparam logic [3:0] REG_ALM   = 4'h9;
	localparam logic [3:0] REG_ALM_L = 4'hc;
	localparam logic [3:0] REG_OFFS  = 4'hd;
	localparam logic [3:0] REG_TMR   = 4'he;
	localparam logic [3:0] REG_CNTDN = 4'hf;

	// Implemented bits of each register, index is the address
	localparam logic [7:0] RD_MASK [REG_COUNT] = '{
		8'hb6, 8'hff, 8'hff, 8'h7f, 8'h3f, 8'h3f, 8'h07, 8'h1f,
		8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'hff, 8'h7b, 8'hff};
	localparam logic [7:0] RST_VAL [REG_COUNT] = '{
		8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01,
		8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h70, 8'h00};

	localparam int unsigned C1_STOP = 5;
	localparam int unsigned C2_MI   = 7;
	localparam int unsigned C2_SI   = 6;
	localparam int unsigned C2_MSF  = 5;
	localparam int unsigned C2_AF   = 3;
	localparam int unsigned C2_TF   = 2;
	localparam int unsigned C2_AIE  = 1;
	localparam int unsigned C2_TIE  = 0;
	localparam logic [7:0]  C2_FLAGS = 8'h2c;
	localparam int unsigned AE_BIT  = 7;
	localparam int unsigned OFS_MODE = 7;
	localparam int unsigned TMR_TE  = 3;
	localparam logic [2:0]  COF_OFF = 3'h7;

	localparam int unsigned CMD_RD_BIT = 7;
	localparam logic [2:0]  CMD_SUB    = 3'h1;

	localparam logic [7:0] BCD_59   = 8'h59;
	localparam logic [7:0] BCD_23   = 8'h23;
	localparam logic [7:0] BCD_12   = 8'h12;
	localparam logic [7:0] WDAY_MAX = 8'h06;

	localparam int unsigned CLK_HZ      = 50_000_000;
	localparam int unsigned SCL_MAX_BPS = 6_250_000;
	localparam int unsigned SCL_MIN_CYC = (CLK_HZ + SCL_MAX_BPS - 1) / SCL_MAX_BPS;

	localparam int unsigned OSC_HZ    = 32768;
	localparam int unsigned DIV_W     = 15;
	localparam logic [15:0] DIV_LAST  = 16'(OSC_HZ - 1);
	localparam int unsigned FAST_BITS = 3;
	localparam int unsigned SLOW_BITS = 9;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_CMD  = 2'b01,
		PH_DATA = 2'b11,
		PH_SKIP = 2'b10
	} phase_e;
endpackage

//--- hdl/time_base.sv
// Oscillator synchroniser and divider: seconds, timer sources, clock taps.
// Assumes osc_i is a free-running 32.768 kHz wave unrelated to clk_i.
module time_base
	import rtc_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             arst_n_i,
	input  wire logic             osc_i,
	input  wire logic             run_i,
	input  wire logic             adjust_i,
	input  wire logic [6:0]       offset_i,
	output logic      [DIV_W-1:0] div_o,
	output logic                  osc_lvl_o,
	output logic                  sec_o,
	output logic                  fast_o,
	output logic                  slow_o
);
	logic        osc_s1_ff, osc_s2_ff, osc_s3_ff;
	logic [15:0] div_ff;
	logic        sec_ff, fast_ff, slow_ff;
	wire         rise_w = osc_s2_ff && !osc_s3_ff;
	// Positive offset shortens the trimmed second, negative lengthens it
	wire  [15:0] last_w = adjust_i ? DIV_LAST - {{9{offset_i[6]}}, offset_i} : DIV_LAST;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			osc_s1_ff <= 1'b0;
			osc_s2_ff <= 1'b0;
			osc_s3_ff <= 1'b0;
			div_ff    <= '0;
			sec_ff    <= 1'b0;
			fast_ff   <= 1'b0;
			slow_ff   <= 1'b0;
		end else begin
			osc_s1_ff <= osc_i;
			osc_s2_ff <= osc_s1_ff;
			osc_s3_ff <= osc_s2_ff;
			sec_ff    <= run_i && rise_w && div_ff == last_w;
			fast_ff   <= rise_w && &div_ff[FAST_BITS-1:0];
			slow_ff   <= rise_w && &div_ff[SLOW_BITS-1:0];
			if (!run_i) begin
				div_ff <= '0;
			end else if (rise_w) begin
				div_ff <= (div_ff == last_w) ? '0 : div_ff + 16'h0001;
			end
		end
	end

	assign div_o     = div_ff[DIV_W-1:0];
	assign osc_lvl_o = osc_s3_ff;
	assign sec_o     = sec_ff;
	assign fast_o    = fast_ff;
	assign slow_o    = slow_ff;
endmodule

//--- hdl/serial_port.sv
// Serial bus shifter: pin synchronisers, byte assembly and read-out shifting.
// Assumes the host samples SDO on rising SCL and shifts MSB first.
module serial_port
	import rtc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       ce_i,
	input  wire logic       scl_i,
	input  wire logic       sdi_i,
	input  wire logic       rd_en_i,
	input  wire logic [7:0] tx_i,
	output logic            active_o,
	output logic            byte_o,
	output logic      [7:0] rx_o,
	output logic            sdo_o,
	output logic            sdo_oe_n_o
);
	logic       ce_s1_ff, ce_s2_ff, scl_s1_ff, scl_s2_ff, scl_s3_ff, sdi_s1_ff, sdi_s2_ff;
	logic [2:0] cnt_ff;
	logic [7:0] rx_ff, tx_ff;
	logic       byte_ff, load_ff, fresh_ff, oe_n_ff;
	wire        rise_w = ce_s2_ff && scl_s2_ff && !scl_s3_ff;
	wire        fall_w = ce_s2_ff && !scl_s2_ff && scl_s3_ff;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{ce_s1_ff, ce_s2_ff, scl_s1_ff, scl_s2_ff, scl_s3_ff} <= '0;
			{sdi_s1_ff, sdi_s2_ff, byte_ff, load_ff, fresh_ff}    <= '0;
			cnt_ff  <= '0;
			rx_ff   <= '0;
			tx_ff   <= '0;
			oe_n_ff <= 1'b1;
		end else begin
			ce_s1_ff  <= ce_i;
			ce_s2_ff  <= ce_s1_ff;
			scl_s1_ff <= scl_i;
			scl_s2_ff <= scl_s1_ff;
			scl_s3_ff <= scl_s2_ff;
			sdi_s1_ff <= sdi_i;
			sdi_s2_ff <= sdi_s1_ff;
			byte_ff   <= rise_w && cnt_ff == 3'h7;
			load_ff   <= byte_ff;
			oe_n_ff   <= !(ce_s2_ff && rd_en_i);
			if (!ce_s2_ff) begin
				cnt_ff <= '0;
			end else if (rise_w) begin
				cnt_ff <= cnt_ff + 3'h1;
				rx_ff  <= {rx_ff[6:0], sdi_s2_ff};
			end
			// First falling edge after a load keeps the MSB on the pin
			if (load_ff) begin
				tx_ff    <= tx_i;
				fresh_ff <= 1'b1;
			end else if (fall_w) begin
				fresh_ff <= 1'b0;
				if (!fresh_ff) begin
					tx_ff <= {tx_ff[6:0], 1'b0};
				end
			end
		end
	end

	assign active_o   = ce_s2_ff;
	assign byte_o     = byte_ff;
	assign rx_o       = rx_ff;
	assign sdo_o      = tx_ff[7];
	assign sdo_oe_n_o = oe_n_ff;
endmodule

//--- hdl/spi_rtc_register_core.sv
// Real-time clock register core: map, BCD calendar, alarm, timers, outputs.
// Assumes a 50 MHz clk_i; all pin inputs are asynchronous to it.
module spi_rtc_register_core
	import rtc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic ce_i,
	input  wire logic scl_i,
	input  wire logic sdi_i,
	input  wire logic osc_i,
	input  wire logic clkoe_i,
	output logic      sdo_o,
	output logic      sdo_oe_n_o,
	output logic      int_oe_n_o,
	output logic      clkout_oe_n_o
);
	logic [7:0]       reg_ff [REG_COUNT];
	logic [7:0]       cd_ff;
	logic [3:0]       addr_ff;
	logic             rd_ff, pend_ff, match_d_ff, clkoe_s1_ff, clkoe_s2_ff;
	logic             int_oe_n_ff, clkout_oe_n_ff;
	phase_e           phase_ff, nxt_phase;
	logic             active, byte_p, sec_p, fast_p, slow_p, osc_lvl;
	logic [7:0]       rx_byte;
	logic [DIV_W-1:0] div;
	logic [7:0]       rd_byte;
	logic             adjust;

	// BCD increment of a two-digit value
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	// Last day of a BCD month, leap years every fourth BCD year
	function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] yr);
		logic [1:0] y4;
		y4 = {yr[4], 1'b0} + yr[1:0];
		case (mon)
			8'h02:                      last_day = (y4 == 2'h0) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
			default:                    last_day = 8'h31;
		endcase
	endfunction

	serial_port u_port (
		.clk_i      (clk_i),
		.arst_n_i   (arst_n_i),
		.ce_i       (ce_i),
		.scl_i      (scl_i),
		.sdi_i      (sdi_i),
		.rd_en_i    (rd_ff && phase_ff == PH_DATA),
		.tx_i       (rd_byte),
		.active_o   (active),
		.byte_o     (byte_p),
		.rx_o       (rx_byte),
		.sdo_o      (sdo_o),
		.sdo_oe_n_o (sdo_oe_n_o)
	);

	time_base u_base (
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.osc_i     (osc_i),
		.run_i     (!reg_ff[REG_CTRL1][C1_STOP]),
		.adjust_i  (adjust),
		.offset_i  (reg_ff[REG_OFFS][6:0]),
		.div_o     (div),
		.osc_lvl_o (osc_lvl),
		.sec_o     (sec_p),
		.fast_o    (fast_p),
		.slow_o    (slow_p)
	);

	// Access decode
	wire [7:0] ctrl2   = reg_ff[REG_CTRL2];
	wire [7:0] tmr     = reg_ff[REG_TMR];
	wire       wr_en   = byte_p && phase_ff == PH_DATA && !rd_ff;
	wire [7:0] wr_data = rx_byte & RD_MASK[addr_ff];
	wire [7:0] rd_raw  = (addr_ff == REG_CNTDN) ? cd_ff : reg_ff[addr_ff];
	assign rd_byte = rd_raw & RD_MASK[addr_ff];
	wire       freeze  = phase_ff != PH_IDLE;
	wire       tick    = (sec_p || pend_ff) && !freeze;

	// Calendar carries
	wire [7:0] sec   = reg_ff[REG_SEC];
	wire [7:0] mins  = reg_ff[4'h3];
	wire [7:0] hours = reg_ff[4'h4];
	wire [7:0] days  = reg_ff[4'h5];
	wire [7:0] wday  = reg_ff[4'h6];
	wire [7:0] mon   = reg_ff[4'h7];
	wire [7:0] year  = reg_ff[REG_YEAR];
	wire       c_min = tick && {1'b0, sec[6:0]} == BCD_59;
	wire       c_hr  = c_min && mins == BCD_59;
	wire       c_day = c_hr && hours == BCD_23;
	wire       c_mon = c_day && days == last_day(mon, year);
	wire       c_yr  = c_mon && mon == BCD_12;
	assign adjust = sec == 8'h00 && (reg_ff[REG_OFFS][OFS_MODE] || mins == 8'h00);

	// Alarm match, a field with its enable bit set is ignored
	wire m_min   = reg_ff[REG_ALM][AE_BIT] || reg_ff[REG_ALM][6:0] == mins[6:0];
	wire m_hr    = reg_ff[4'ha][AE_BIT] || reg_ff[4'ha][5:0] == hours[5:0];
	wire m_day   = reg_ff[4'hb][AE_BIT] || reg_ff[4'hb][5:0] == days[5:0];
	wire m_wday  = reg_ff[REG_ALM_L][AE_BIT] || reg_ff[REG_ALM_L][2:0] == wday[2:0];
	wire any_ae  = !(reg_ff[REG_ALM][AE_BIT] && reg_ff[4'ha][AE_BIT]
		&& reg_ff[4'hb][AE_BIT] && reg_ff[REG_ALM_L][AE_BIT]);
	wire match   = any_ae && m_min && m_hr && m_day && m_wday;
	wire alarm_hit = match && !match_d_ff;

	// Countdown source select
	logic src_tick;
	always_comb begin
		case (tmr[1:0])
			2'h0:    src_tick = fast_p;
			2'h1:    src_tick = slow_p;
			2'h2:    src_tick = tick;
			default: src_tick = c_min;
		endcase
	end
	wire cd_tick  = tmr[TMR_TE] && src_tick;
	wire cd_fire  = cd_tick && cd_ff == 8'h01;
	wire per_hit  = (ctrl2[C2_SI] && tick) || (ctrl2[C2_MI] && c_min);

	// Flag bits: host writes zero to clear, a new event wins
	wire [7:0] set_flags = {2'b00, per_hit, 1'b0, alarm_hit, cd_fire, 2'b00};
	wire [7:0] c2_base   = (wr_en && addr_ff == REG_CTRL2)
		? (wr_data & ~C2_FLAGS) | (wr_data & ctrl2 & C2_FLAGS) : ctrl2;
	wire [7:0] nxt_ctrl2 = c2_base | set_flags;
	wire       irq = (ctrl2[C2_AF] && ctrl2[C2_AIE]) || (ctrl2[C2_TF] && ctrl2[C2_TIE])
		|| ctrl2[C2_MSF];

	// Clock output tap
	logic clk_lvl;
	always_comb begin
		case (tmr[6:4])
			3'h0:    clk_lvl = osc_lvl;
			3'h1:    clk_lvl = div[0];
			3'h2:    clk_lvl = div[1];
			3'h3:    clk_lvl = div[2];
			3'h4:    clk_lvl = div[4];
			default: clk_lvl = div[DIV_W-1];
		endcase
	end
	wire clk_pull = clkoe_s2_ff && tmr[6:4] != COF_OFF && !clk_lvl;

	// Next values of the calendar counters
	logic [7:0] nxt_time [REG_SEC:REG_YEAR];
	wire  [7:0] sec_inc = bcd_inc(sec);
	assign nxt_time[REG_SEC] = c_min ? {sec[7], 7'h00} : {sec[7], sec_inc[6:0]};
	assign nxt_time[4'h3] = c_hr ? 8'h00 : bcd_inc(mins);
	assign nxt_time[4'h4] = c_day ? 8'h00 : bcd_inc(hours);
	assign nxt_time[4'h5] = c_mon ? 8'h01 : bcd_inc(days);
	assign nxt_time[4'h6] = (wday == WDAY_MAX) ? 8'h00 : bcd_inc(wday);
	assign nxt_time[4'h7] = c_yr ? 8'h01 : bcd_inc(mon);
	assign nxt_time[REG_YEAR] = (year == 8'h99) ? 8'h00 : bcd_inc(year);
	wire [REG_YEAR:REG_SEC] adv = {c_yr, c_mon, c_day, c_day, c_hr, c_min, tick};

	always_comb begin
		case (phase_ff)
			PH_IDLE: nxt_phase = active ? PH_CMD : PH_IDLE;
			PH_CMD:  nxt_phase = !active ? PH_IDLE : !byte_p ? PH_CMD
				: (rx_byte[6:4] == CMD_SUB) ? PH_DATA : PH_SKIP;
			PH_DATA: nxt_phase = active ? PH_DATA : PH_IDLE;
			PH_SKIP: nxt_phase = active ? PH_SKIP : PH_IDLE;
			default: nxt_phase = PH_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phase_ff <= PH_IDLE;
			addr_ff  <= '0;
			{rd_ff, pend_ff, match_d_ff, clkoe_s1_ff, clkoe_s2_ff} <= '0;
		end else begin
			phase_ff    <= nxt_phase;
			match_d_ff  <= match;
			clkoe_s1_ff <= clkoe_i;
			clkoe_s2_ff <= clkoe_s1_ff;
			pend_ff     <= (sec_p && freeze) || (pend_ff && freeze);
			if (byte_p && phase_ff == PH_CMD) begin
				addr_ff <= rx_byte[3:0];
				rd_ff   <= rx_byte[CMD_RD_BIT];
			end else if (byte_p && phase_ff == PH_DATA) begin
				addr_ff <= addr_ff + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				reg_ff[i] <= RST_VAL[i];
			end
			cd_ff <= '0;
		end else begin
			for (int i = 0; i < REG_COUNT; i++) begin
				if (wr_en && addr_ff == 4'(i)) begin
					reg_ff[i] <= wr_data;
				end
			end
			for (int i = REG_SEC; i <= REG_YEAR; i++) begin
				if (adv[i]) begin
					reg_ff[i] <= nxt_time[i];
				end
			end
			reg_ff[REG_CTRL2] <= nxt_ctrl2;
			if (wr_en && addr_ff == REG_CNTDN) begin
				cd_ff <= wr_data;
			end else if (cd_fire) begin
				cd_ff <= reg_ff[REG_CNTDN];
			end else if (cd_tick && cd_ff > 8'h01) begin
				cd_ff <= cd_ff - 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			int_oe_n_ff    <= 1'b1;
			clkout_oe_n_ff <= 1'b1;
		end else begin
			int_oe_n_ff    <= !irq;
			clkout_oe_n_ff <= !clk_pull;
		end
	end

	assign int_oe_n_o    = int_oe_n_ff;
	assign clkout_oe_n_o = clkout_oe_n_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	a_addr_step: assert property (byte_p && phase_ff == PH_DATA
		|=> addr_ff == $past(addr_ff) + 4'h1) else $error("address did not advance");
	a_addr_wrap: assert property (byte_p && phase_ff == PH_DATA && addr_ff == 4'hf
		|=> addr_ff == 4'h0) else $error("address did not wrap");
	a_ctrl_decode: assert property (wr_en && addr_ff == REG_CTRL1
		|=> reg_ff[REG_CTRL1] == ($past(rx_byte) & RD_MASK[0])) else $error("ctrl write lost");
	a_bcd_digit: assert property (reg_ff[REG_SEC][3:0] <= 4'h9 && mins[3:0] <= 4'h9)
		else $error("time digit not bcd");
	a_freeze_hold: assert property (freeze && !wr_en |=> $stable(reg_ff[REG_SEC]))
		else $error("seconds moved during access");
	a_pend_apply: assert property (pend_ff && !active && phase_ff == PH_IDLE
		|=> !pend_ff && reg_ff[REG_SEC] != $past(reg_ff[REG_SEC])) else $error("tick lost");
	a_alarm_flag: assert property (alarm_hit |=> ctrl2[C2_AF])
		else $error("alarm flag not set");
	a_timer_fire: assert property (cd_fire && !wr_en
		|=> ctrl2[C2_TF] && cd_ff == reg_ff[REG_CNTDN]) else $error("timer reload wrong");
	a_second_irq: assert property (tick && ctrl2[C2_SI] |=> ##1 !int_oe_n_o)
		else $error("second interrupt missing");
	a_read_mask: assert property ((reg_ff[addr_ff] & ~RD_MASK[addr_ff]) == 8'h00)
		else $error("unimplemented bit read high");
	a_clkout_off: assert property (tmr[6:4] == COF_OFF |=> clkout_oe_n_o)
		else $error("clock output not off");
	// Calendar carries, timer, bus and output guards
	a_min_carry: assert property (c_min
		|=> reg_ff[REG_SEC][6:0] == 7'h00)
		else $error("seconds did not wrap");
	a_hour_wrap: assert property (c_day
		|=> hours == 8'h00)
		else $error("hours did not wrap");
	a_wday_wrap: assert property (c_day && wday == WDAY_MAX
		|=> wday == 8'h00)
		else $error("weekday did not wrap");
	a_year_wrap: assert property (c_yr && year == 8'h99
		|=> year == 8'h00)
		else $error("year did not wrap");
	a_month_wrap: assert property (c_yr
		|=> mon == 8'h01 && days == 8'h01)
		else $error("month or day did not restart");
	a_stop_hold: assert property (reg_ff[REG_CTRL1][C1_STOP]
		|=> !sec_p)
		else $error("seconds tick while stopped");
	a_clkout_gate: assert property (!clkoe_s2_ff
		|=> clkout_oe_n_o)
		else $error("clock output not gated");
	a_pend_hold: assert property (sec_p && freeze
		|=> pend_ff)
		else $error("tick during access not held");
	a_cd_step: assert property (cd_tick && cd_ff > 8'h01 && !(wr_en && addr_ff == REG_CNTDN)
		|=> cd_ff == $past(cd_ff) - 8'h01)
		else $error("countdown did not step");
	a_cd_idle: assert property (!tmr[TMR_TE] && !(wr_en && addr_ff == REG_CNTDN)
		|=> $stable(cd_ff))
		else $error("countdown moved while disabled");
	a_flag_clear: assert property (wr_en && addr_ff == REG_CTRL2 && !rx_byte[C2_MSF] && !per_hit
		|=> !ctrl2[C2_MSF])
		else $error("periodic flag not cleared");
	a_int_idle: assert property (!irq
		|=> int_oe_n_o)
		else $error("interrupt pulled without cause");
	a_addr_load: assert property (byte_p && phase_ff == PH_CMD
		|=> addr_ff == $past(rx_byte[3:0]))
		else $error("address not loaded from command");
	a_sdo_idle: assert property (!active
		|=> sdo_oe_n_o)
		else $error("sdo driven without chip enable");
	a_skip_quiet: assert property (phase_ff == PH_SKIP
		|=> sdo_oe_n_o)
		else $error("sdo driven after bad command");

	c_read_burst: cover property (byte_p && phase_ff == PH_DATA && rd_ff ##[1:200] byte_p);
	c_alarm_hit:  cover property (alarm_hit);
	c_timer_fire: cover property (cd_fire);
	c_pend_tick:  cover property (pend_ff ##1 !pend_ff);
	c_skip_cmd:   cover property (phase_ff == PH_SKIP);
endmodule

//--- verification/rtc_host_model.sv
// Host side of the serial bus: chip enable, serial clock and bit shifting.
// Assumes the core releases SDO outside reads; the bench calls xfer().
module rtc_host_model
	import rtc_pkg::*;
#(
	parameter int unsigned HALF = 5
)
(
	input  wire logic clk_i,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_n_i,
	output logic      ce_o,
	output logic      scl_o,
	output logic      sdi_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] tx_q [16];
	logic [7:0] rx_q [16];
	logic       drove;
	logic       last_drv;
	wire        line;

	// Released SDO shows the inverse of the last driven bit
	assign line = sdo_oe_n_i ? ~last_drv : sdo_i;

	initial begin
		ce_o  = 1'b0;
		scl_o = 1'b0;
		sdi_o = 1'b0;
		last_drv = 1'b0;
		drove = 1'b0;
		foreach (tx_q[i])
			tx_q[i] = 8'h00;
	end

	always @(posedge clk_i) begin
		if (!sdo_oe_n_i)
			last_drv <= sdo_i;
		if (ce_o && !sdo_oe_n_i)
			drove <= 1'b1;
	end

	// Half period of HALF clk keeps SCL at or below 6.25 Mbit/s
	task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int b = 7; b >= 0; b--) begin
			sdi_o <= tx[b];
			repeat (HALF) @(posedge clk_i);
			scl_o <= 1'b1;
			@(negedge clk_i);
			rx[b] = line;
			repeat (HALF) @(posedge clk_i);
			scl_o <= 1'b0;
		end
	endtask

	// Command byte, then n whole data bytes; SCL idles low between frames
	task automatic xfer(input logic [7:0] cmd, input int n);
		logic [7:0] rx;
		@(posedge clk_i);
		drove = 1'b0;
		ce_o <= 1'b1;
		repeat (HALF) @(posedge clk_i);
		shift_byte(cmd, rx);
		for (int i = 0; i < n; i++)
			shift_byte(tx_q[i], rx_q[i]);
		repeat (HALF) @(posedge clk_i);
		ce_o <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

//--- verification/spi_rtc_register_core_test.sv
// Self-checking bench for the real-time clock register core.
// Assumes the host model drives the serial pins; osc runs at 8 clk per period.
module spi_rtc_register_core_test
	import rtc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk;
	logic       arst_n;
	logic       osc;
	logic       clkoe;
	logic [1:0] osc_cnt;
	wire        ce;
	wire        scl;
	wire        sdi;
	wire        sdo;
	wire        sdo_oe_n;
	wire        int_oe_n;
	wire        clkout_oe_n;
	int         bad_count;
	int         cmp_count;
	int         cyc;
	int         edges;
	logic [7:0] tv [7] = '{8'h45, 8'h59, 8'h23, 8'h28, 8'h05, 8'h02, 8'h24};
	int         ld [2] = '{3, 1};
	int         per [2] = '{64, 4096};
	logic [2:0] ck_cof [4] = '{3'h3, 3'h0, 3'h3, 3'h7};
	logic       ck_en [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
	int         ck_exp [4] = '{20, 160, 0, 0};

	spi_rtc_register_core dut_u (.clk_i(clk), .arst_n_i(arst_n), .ce_i(ce), .scl_i(scl),
		.sdi_i(sdi), .osc_i(osc), .clkoe_i(clkoe), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
		.int_oe_n_o(int_oe_n), .clkout_oe_n_o(clkout_oe_n));
	rtc_host_model host_u (.clk_i(clk), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n), .ce_o(ce),
		.scl_o(scl), .sdi_o(sdi));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Oscillator stand-in, faster than real to keep the run short
	always @(posedge clk) begin
		osc_cnt <= osc_cnt + 2'd1;
		if (osc_cnt == 2'd3)
			osc <= ~osc;
	end

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] addr, input int n);
		host_u.xfer({1'b0, CMD_SUB, addr}, n);
	endtask

	task automatic rd(input logic [3:0] addr, input int n);
		host_u.xfer({1'b1, CMD_SUB, addr}, n);
	endtask

	task automatic wr1(input logic [3:0] addr, input logic [7:0] d);
		host_u.tx_q[0] = d;
		wr(addr, 1);
	endtask

	task automatic wait_int(input logic lvl, input int limit);
		cyc = 0;
		while (int_oe_n !== lvl && cyc < limit) begin
			@(negedge clk);
			cyc++;
		end
		cmp_count++;
		if (int_oe_n !== lvl) begin
			bad_count++;
			$display("ERROR int_oe_n expected %b seen %b", lvl, int_oe_n);
			report_and_stop();
		end
	endtask

	task automatic count_clkout(input int n);
		logic prev;
		edges = 0;
		prev = clkout_oe_n;
		repeat (n) begin
			@(negedge clk);
			if (prev && !clkout_oe_n)
				edges++;
			prev = clkout_oe_n;
		end
	endtask

	initial begin
		arst_n = 1'b0;
		clkoe = 1'b0;
		osc = 1'b0;
		osc_cnt = 2'd0;
		bad_count = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		// Whole map in one burst straight after reset
		rd(REG_CTRL1, 16);
		for (int i = 0; i < 16; i++)
			check($sformatf("reg %h", i), RST_VAL[i], host_u.rx_q[i]);
		// Alarm and offset: only implemented bits stick
		for (int i = 0; i < 5; i++)
			host_u.tx_q[i] = 8'hff;
		wr(REG_ALM, 5);
		rd(REG_ALM, 5);
		for (int i = 0; i < 5; i++)
			check($sformatf("reg %h", i + 9), RD_MASK[i + 9], host_u.rx_q[i]);
		// Calendar counters in BCD
		for (int i = 0; i < 7; i++)
			host_u.tx_q[i] = tv[i];
		wr(REG_SEC, 7);
		rd(REG_SEC, 7);
		for (int i = 0; i < 7; i++)
			check($sformatf("reg %h", i + 2), tv[i], host_u.rx_q[i]);
		// Burst past the last register lands on the control registers
		host_u.tx_q[0] = 8'h05;
		host_u.tx_q[1] = 8'h00;
		host_u.tx_q[2] = 8'h03;
		wr(REG_CNTDN, 3);
		rd(REG_CNTDN, 3);
		check("wrap reg f", 8'h05, host_u.rx_q[0]);
		check("wrap reg 0", 8'h00, host_u.rx_q[1]);
		check("wrap reg 1", 8'h03, host_u.rx_q[2]);
		// Bad command pattern: no SDO drive, no register change
		host_u.tx_q[0] = 8'h00;
		host_u.xfer(8'had, 1);
		check("sdo driven", 8'h00, {7'h00, host_u.drove});
		host_u.xfer(8'h2d, 1);
		rd(REG_OFFS, 1);
		check("reg d", 8'hff, host_u.rx_q[0]);
		// Alarm on minutes only
		wr1(REG_CTRL2, 8'h02);
		wr1(4'h3, 8'h30);
		wr1(REG_ALM, 8'h30);
		wait_int(1'b0, 50);
		rd(REG_CTRL2, 1);
		check("alarm flag", 8'h0a, host_u.rx_q[0]);
		wr1(REG_ALM, 8'h80);
		wr1(REG_CTRL2, 8'h00);
		wait_int(1'b1, 10);
		// Countdown sources; the two fast ones are timed
		for (int s = 0; s < 4; s++) begin
			wr1(REG_CTRL2, 8'h01);
			host_u.tx_q[0] = 8'h78 | 8'(s);
			host_u.tx_q[1] = (s < 2) ? 8'(ld[s]) : 8'h02;
			wr(REG_TMR, 2);
			if (s < 2) begin
				wait_int(1'b0, per[s] * ld[s] + 200);
				cmp_count++;
				if (cyc + 40 < per[s] * (ld[s] - 1)) begin
					bad_count++;
					$display("ERROR countdown cycles expected %0d seen %0d", per[s] * ld[s], cyc);
				end
				rd(REG_CTRL2, 1);
				check("timer flag", 8'h05, host_u.rx_q[0]);
			end
			rd(REG_TMR, 1);
			check("reg e", 8'h78 | 8'(s), host_u.rx_q[0]);
			wr1(REG_TMR, 8'h70);
			wr1(REG_CTRL2, 8'h00);
			wait_int(1'b1, 10);
		end
		// Clock output rates from the oscillator and a divider tap, gated by clkoe
		for (int k = 0; k < 4; k++) begin
			clkoe <= ck_en[k];
			wr1(REG_TMR, {1'b0, ck_cof[k], 4'h0});
			count_clkout(1280);
			cmp_count++;
			if (edges + 1 < ck_exp[k] || edges > ck_exp[k] + 1) begin
				bad_count++;
				$display("ERROR clkout edges expected %0d seen %0d", ck_exp[k], edges);
			end
		end
		report_and_stop();
	end
endmodule
